/* File: shared/core_decode_regs.svh */
// constants for the instruction decode and execute block
`ifndef CORE_DECODE_REGS_SVH
`define CORE_DECODE_REGS_SVH

`define IWORD_W        14
`define FADDR_W        7
`define PC_W           13
`define OSC_PER_CYCLE  2'h3
`define OP_LIT_ADD     5'h1F
`define OP_LIT_AND     6'h39
`define OP_ADD_FILE    6'h07
`define OP_AND_FILE    6'h05
`define OP_CLR_GROUP   6'h01
`define OP_CALL        3'h4
`define OP_BIT_SKIP1   4'h7
`define ZERO_ACCUMULATOR_WORD      14'h0103
`define LATCH_HI_BIT   4
`define LATCH_LO_BIT   3
`define NOP_WORD       14'h0000

`endif

/* File: shared/core_decode_pkg.sv */
// types shared by the instruction decode and execute block
package core_decode_pkg;

    typedef enum logic [2:0]
    {
        op_nop       = 3'b000,
        op_lit_add   = 3'b001,
        op_lit_and   = 3'b010,
        op_file_add  = 3'b011,
        op_file_and  = 3'b100,
        op_bit_skip  = 3'b101,
        op_clr_file  = 3'b110,
        op_call      = 3'b111
    } op_e;

    typedef struct packed
    {
        op_e        op;
        logic       dest_file;
        logic [6:0] faddr;
        logic [2:0] bit_index;
        logic [7:0] literal;
        logic [10:0] target;
        logic       clr_acc;
    } decoded_s;

    typedef struct packed
    {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_write_s;

endpackage : core_decode_pkg

/* File: verilog/instr_field_decoder.sv */
// field decoder that splits a 14-bit instruction word into its operands
`timescale 1ns/1ps
`include "core_decode_regs.svh"

module instr_field_decoder
    import core_decode_pkg::*;
(
    input  wire logic [13:0] word,     // fetched instruction word
    output decoded_s         fields    // decoded operation and operands
);

    always_comb
    begin
        fields           = '0;
        fields.dest_file = word[7];
        fields.faddr     = word[`FADDR_W-1:0];
        fields.bit_index = word[9:7];
        fields.literal   = word[7:0];
        fields.target    = word[10:0];
        fields.op        = op_nop;
        // x bits are not compared, so either value decodes the same, except in ZERO_ACCUMULATOR_WORD, which is matched in full
        if (word[13:9] == `OP_LIT_ADD)
            fields.op = op_lit_add;
        else if (word[13:8] == `OP_LIT_AND)
            fields.op = op_lit_and;
        else if (word[13:11] == `OP_CALL)
            fields.op = op_call;
        else if (word[13:10] == `OP_BIT_SKIP1)
            fields.op = op_bit_skip;
        else if (word[13:8] == `OP_ADD_FILE)
            fields.op = op_file_add;
        else if (word[13:8] == `OP_AND_FILE)
            fields.op = op_file_and;
        else if (word[13:8] == `OP_CLR_GROUP && word[7])
            fields.op = op_clr_file;
        else if (word == `ZERO_ACCUMULATOR_WORD)
        begin
            fields.op      = op_lit_and;
            fields.literal = 8'h00;
            fields.clr_acc = 1'b1;
        end
    end

endmodule : instr_field_decoder

/* File: verilog/instr_exec_core.sv */
// instruction decode and execute for a subset of the 14-bit instruction set
`timescale 1ns/1ps
`include "core_decode_regs.svh"

module instr_exec_core
    import core_decode_pkg::*;
(
    input  wire logic        clk,            // oscillator clock, 50 MHz
    input  wire logic        nrst,           // asynchronous reset, active low
    input  wire logic [13:0] prog_word,      // program memory word at fetch_addr
    input  wire logic [7:0]  file_rdata,     // file register at file_addr, same clock
    input  wire logic [4:0]  program_counter_high_latch, // upper pc source
    output logic      [12:0] fetch_addr,     // program counter
    output logic      [6:0]  file_addr,      // file register address
    output logic             file_we,        // file write strobe, one clock
    output logic      [7:0]  file_wdata,     // file write data
    output logic             push,           // stack push strobe, one clock
    output logic      [12:0] stack_top,      // return address pushed
    output logic      [7:0]  acc,            // working register
    output logic             carry,          // carry flag
    output logic             half_carry_flag,// digit carry flag
    output logic             zero,           // zero flag
    output logic             cycle_strobe    // one clock at each instruction end
);

    // ****************************************************************
    // instruction cycle divider
    // ****************************************************************
    logic [1:0] phase;
    logic       cycle_end;

    // four oscillator periods make one instruction cycle
    // phase restarts at zero on reset, so the first word is taken on the fourth edge
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end

    assign cycle_end = (phase == `OSC_PER_CYCLE);

    // ****************************************************************
    // pipeline: one word fetched while the previous executes
    // ****************************************************************
    logic [13:0] ir;
    logic        flush;
    decoded_s    dec;

    instr_field_decoder u_dec
    (
        .word   (ir),
        .fields (dec)
    );

    // ****************************************************************
    // operand and result path
    // ****************************************************************
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] operand;
    logic [7:0] result;
    logic       writes_flags_add;
    logic       bit_set;
    logic       dest_acc;

    // ****************************************************************
    // decode and arithmetic helpers
    // ****************************************************************
    function automatic logic [8:0] add8(input logic [7:0] a, input logic [7:0] b);
        add8 = {1'b0, a} + {1'b0, b};
    endfunction : add8

    function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b);
        add4 = {1'b0, a} + {1'b0, b};
    endfunction : add4

    // literal forms take their operand from the word itself
    function automatic logic is_literal_op(input op_e op);
        is_literal_op = (op == op_lit_add) || (op == op_lit_and);
    endfunction : is_literal_op

    // byte forms read the file register that file_addr points at
    function automatic logic is_file_op(input op_e op);
        is_file_op = (op == op_file_add) || (op == op_file_and);
    endfunction : is_file_op

    // adds update carry and half carry, the and forms leave them alone
    function automatic logic is_add_op(input op_e op);
        is_add_op = (op == op_lit_add) || (op == op_file_add);
    endfunction : is_add_op

    // sequential fetch; the counter wraps at the top of program space
    function automatic logic [12:0] pc_plus_one(input logic [12:0] pc);
        pc_plus_one = pc + 13'h0001;
    endfunction : pc_plus_one

    always_comb
    begin
        operand = is_literal_op(dec.op) ? dec.literal : file_rdata;
        // both sums are formed every clock; only the add forms pass them on
        sum     = add8(acc, operand);
        low_sum = add4(acc[3:0], operand[3:0]);
        result  = 8'h00;
        unique case (dec.op)
            op_lit_add, op_file_add : result = sum[7:0];
            op_lit_and, op_file_and : result = acc & operand;
            default                 : result = 8'h00;
        endcase
        writes_flags_add = is_add_op(dec.op);
        bit_set  = file_rdata[dec.bit_index];
        // literal forms always land in the accumulator, byte forms only with d=0
        dest_acc = is_literal_op(dec.op) || (is_file_op(dec.op) && !dec.dest_file);
    end

    // the operand address trails ir by one clock so that it leaves a flop;
    // the file read then has three clocks to settle before the cycle end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            file_addr <= 7'h00;
        else
            file_addr <= ir[`FADDR_W-1:0];
    end

    // ****************************************************************
    // instruction register and program counter
    // ****************************************************************
    // a taken skip or a call keeps the word fetched behind it in ir but
    // marks it squashed, so fetch_addr still moves once per cycle, stepping after a skip and jumping to the target after a call
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ir         <= `NOP_WORD;
            flush      <= 1'b0;
            fetch_addr <= 13'h0000;
        end
        else if (cycle_end)
        begin
            if (flush)
            begin
                // the squashed word has had its cycle as a nop
                ir         <= prog_word;
                flush      <= 1'b0;
                fetch_addr <= pc_plus_one(fetch_addr);
            end
            else if (dec.op == op_call)
            begin
                // the word fetched behind the call is loaded but squashed
                ir         <= prog_word;
                flush      <= 1'b1;
                fetch_addr <= {program_counter_high_latch[`LATCH_HI_BIT:`LATCH_LO_BIT],
                               dec.target};
            end
            else if (dec.op == op_bit_skip && bit_set)
            begin
                ir         <= prog_word;
                flush      <= 1'b1;
                fetch_addr <= pc_plus_one(fetch_addr);
            end
            else
            begin
                ir         <= prog_word;
                fetch_addr <= pc_plus_one(fetch_addr);
            end
        end
    end

    // ****************************************************************
    // stack push for calls
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            push      <= 1'b0;
            stack_top <= 13'h0000;
        end
        else
        begin
            push <= cycle_end && !flush && (dec.op == op_call);
            // fetch_addr already points past the call: it is the return address
            if (cycle_end && !flush && dec.op == op_call)
                stack_top <= fetch_addr;
        end
    end

    // ****************************************************************
    // working register
    // ****************************************************************
    // a squashed word never reaches the accumulator
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            acc <= 8'h00;
        else if (cycle_end && !flush && dest_acc)
            acc <= result;
    end

    // ****************************************************************
    // file write port
    // ****************************************************************
    // the strobe follows the cycle end by one clock, while file_addr
    // still holds the operand address of the word that just finished
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            file_we    <= 1'b0;
            file_wdata <= 8'h00;
        end
        else
        begin
            file_we <= 1'b0;
            if (cycle_end && !flush)
            begin
                if (dec.op == op_clr_file)
                begin
                    file_we    <= 1'b1;
                    file_wdata <= 8'h00;
                end
                else if (is_file_op(dec.op) && dec.dest_file)
                begin
                    file_we    <= 1'b1;
                    file_wdata <= result;
                end
            end
        end
    end

    // ****************************************************************
    // carry and half carry
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            carry           <= 1'b0;
            half_carry_flag <= 1'b0;
        end
        else if (cycle_end && !flush && writes_flags_add)
        begin
            carry           <= sum[8];
            half_carry_flag <= low_sum[4];
        end
    end

    // ****************************************************************
    // zero flag
    // ****************************************************************
    // the file clear forces the flag, since its result never passes through
    // the adder or the and gate
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            zero <= 1'b0;
        else if (cycle_end && !flush)
        begin
            unique case (dec.op)
                op_lit_add, op_file_add : zero <= (result == 8'h00);
                op_lit_and, op_file_and : zero <= (result == 8'h00);
                op_clr_file             : zero <= 1'b1;
                default                 : zero <= zero;
            endcase
        end
    end

    // ****************************************************************
    // instruction cycle strobe
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cycle_strobe <= 1'b0;
        else
            cycle_strobe <= cycle_end;
    end

endmodule : instr_exec_core

/* File: sim/instr_exec_core_sva.sv */
// concurrent checks on the ports of the instruction execute core
`timescale 1ns/1ps
module instr_exec_core_sva
(
    input wire logic        clk,                        // clock
    input wire logic        nrst,                       // reset, active low
    input wire logic [4:0]  program_counter_high_latch, // upper pc source
    input wire logic [12:0] fetch_addr,                 // program counter
    input wire logic        file_we,                    // file write strobe
    input wire logic [7:0]  file_wdata,                 // file write data
    input wire logic        push,                       // stack push strobe
    input wire logic [7:0]  acc,                        // working register
    input wire logic        zero,                       // zero flag
    input wire logic        cycle_strobe                // cycle end strobe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence quiet_then_strobe;
        !cycle_strobe [*3] ##1 cycle_strobe;
    endsequence
    sequence quiet_push;
        !push [*7];
    endsequence

    a_strobe_period: assert property (cycle_strobe |=> quiet_then_strobe)
        else $error("cycle strobe not four clocks apart");
    a_pc_step: assert property (cycle_strobe && !push |->
        fetch_addr == $past(fetch_addr, 4) + 13'h0001)
        else $error("program counter did not step by one");
    a_strobe_pairs: assert property (file_we || push |-> cycle_strobe)
        else $error("write or push away from cycle end");
    a_push_gap: assert property (push |=> quiet_push)
        else $error("call did not take two cycles");
    a_call_high: assert property (push |->
        fetch_addr[12:11] == program_counter_high_latch[4:3])
        else $error("call upper pc bits wrong");
    a_zero_acc: assert property ($changed(acc) |-> zero == (acc == 8'h00))
        else $error("zero flag disagrees with accumulator");
    a_zero_file: assert property (file_we |-> zero == (file_wdata == 8'h00))
        else $error("zero flag disagrees with file result");
    a_acc_timing: assert property ($changed(acc) |-> ##[0:1] cycle_strobe)
        else $error("accumulator changed mid cycle");
    a_call_squash: assert property (push |=> $stable(acc) [*4])
        else $error("word behind a call reached the accumulator");
endmodule : instr_exec_core_sva

bind instr_exec_core instr_exec_core_sva i_chk
(
    .clk                        (clk),
    .nrst                       (nrst),
    .program_counter_high_latch (program_counter_high_latch),
    .fetch_addr                 (fetch_addr),
    .file_we                    (file_we),
    .file_wdata                 (file_wdata),
    .push                       (push),
    .acc                        (acc),
    .zero                       (zero),
    .cycle_strobe               (cycle_strobe)
);

/* File: sim/prog_file_model.sv */
// program memory and file register space facing the execute core
`timescale 1ns/1ps
module prog_file_model
(
    input  wire logic        clk,        // core clock
    input  wire logic [12:0] fetch_addr, // program counter
    output logic      [13:0] prog_word,  // word at fetch_addr
    input  wire logic [6:0]  file_addr,  // file register address
    output logic      [7:0]  file_rdata, // contents at file_addr
    input  wire logic        file_we,    // write strobe
    input  wire logic [7:0]  file_wdata  // write data
);
    // plain always: the bench also preloads these arrays
    logic [13:0] prog_mem [0:8191];
    logic [7:0]  file_mem [0:127];
    assign prog_word  = prog_mem[fetch_addr];
    assign file_rdata = file_mem[file_addr];
    always @(posedge clk)
    begin
        if (file_we)
            file_mem[file_addr] <= file_wdata;
    end
endmodule : prog_file_model

/* File: sim/tb_risc_core_instr_decode_subset.sv */
// self-checking bench for the instruction execute core
`timescale 1ns/1ps
module tb_risc_core_instr_decode_subset;
    logic        clk;
    logic        nrst;
    logic [4:0]  high_latch;
    logic [13:0] prog_word;
    logic [7:0]  file_rdata;
    logic [12:0] fetch_addr;
    logic [6:0]  file_addr;
    logic        file_we;
    logic [7:0]  file_wdata;
    logic [12:0] stack_top;
    logic [7:0]  acc;
    logic        carry;
    logic        half_carry_flag;
    logic        zero;
    logic        cycle_strobe;
    int          failures;
    int          checked;

    instr_exec_core i_dut (.clk(clk), .nrst(nrst), .prog_word(prog_word),
        .file_rdata(file_rdata), .program_counter_high_latch(high_latch),
        .fetch_addr(fetch_addr), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .push(), .stack_top(stack_top), .acc(acc),
        .carry(carry), .half_carry_flag(half_carry_flag), .zero(zero),
        .cycle_strobe(cycle_strobe));
    prog_file_model i_mem (.clk(clk), .fetch_addr(fetch_addr), .prog_word(prog_word),
        .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
        .file_wdata(file_wdata));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // waits for n cycle ends, bounded, then one more clock for file writes
    task automatic step(input int n);
        int seen;
        int t;
        seen = 0;
        t = 0;
        while (seen < n && t < 4 * n + 8)
        begin
            @(negedge clk);
            t++;
            if (cycle_strobe === 1'b1)
                seen++;
        end
        check(16'(seen), 16'(n));
        @(negedge clk);
    endtask : step

    // memory outside a program reads as the empty word, which runs as nop
    task automatic restart;
        nrst = 1'b0;
        for (int i = 0; i < 8192; i++)
            i_mem.prog_mem[i] = 14'h0000;
        for (int i = 0; i < 128; i++)
            i_mem.file_mem[i] = 8'h00;
    endtask : restart

    task automatic go(input int n);
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        step(n);
    endtask : go

    task automatic literal_ops;
        restart();
        i_mem.prog_mem[0] = 14'h3E15;
        i_mem.prog_mem[1] = 14'h3FF0;
        i_mem.prog_mem[2] = 14'h3E0B;
        i_mem.prog_mem[3] = 14'h390F;
        go(3);
        check(acc, 8'h05);
        check({carry, half_carry_flag, zero}, 3'b100);
        step(2);
        check(acc, 8'h00);
        check({carry, half_carry_flag, zero}, 3'b011);
    endtask : literal_ops

    task automatic file_ops;
        restart();
        i_mem.file_mem[127] = 8'hC2;
        i_mem.file_mem[0] = 8'h27;
        i_mem.prog_mem[0] = 14'h3E17;
        i_mem.prog_mem[1] = 14'h077F;
        i_mem.prog_mem[2] = 14'h05FF;
        i_mem.prog_mem[3] = 14'h0780;
        go(5);
        check(acc, 8'hD9);
        check(i_mem.file_mem[127], 8'hC0);
        check(i_mem.file_mem[0], 8'h00);
        check({carry, half_carry_flag, zero}, 3'b111);
    endtask : file_ops

    task automatic clear_ops;
        restart();
        i_mem.file_mem[64] = 8'h5A;
        i_mem.prog_mem[0] = 14'h3E5A;
        i_mem.prog_mem[1] = 14'h01C0;
        i_mem.prog_mem[2] = 14'h3E01;
        i_mem.prog_mem[3] = 14'h0103;
        go(3);
        check(i_mem.file_mem[64], 8'h00);
        check({acc, zero}, 9'h0B5);
        step(2);
        check({acc, zero}, 9'h001);
    endtask : clear_ops

    task automatic skip_ops;
        restart();
        i_mem.file_mem[16] = 8'h80;
        i_mem.file_mem[17] = 8'h08;
        i_mem.prog_mem[0] = 14'h1F90;
        i_mem.prog_mem[1] = 14'h3E01;
        i_mem.prog_mem[2] = 14'h3E02;
        i_mem.prog_mem[3] = 14'h1C10;
        i_mem.prog_mem[4] = 14'h3E04;
        i_mem.prog_mem[5] = 14'h1D91;
        i_mem.prog_mem[6] = 14'h3E08;
        i_mem.prog_mem[7] = 14'h3E10;
        go(9);
        check(acc, 8'h16);
    endtask : skip_ops

    task automatic call_ops;
        restart();
        i_mem.prog_mem[0] = 14'h3E01;
        i_mem.prog_mem[1] = 14'h2123;
        i_mem.prog_mem[2] = 14'h3E40;
        i_mem.prog_mem[13'h1923] = 14'h3E10;
        go(5);
        check(acc, 8'h11);
        check(stack_top, 13'h0002);
        check(fetch_addr, 13'h1925);
    endtask : call_ops

    task automatic conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (3000) @(posedge clk);
        failures++;
        conclude();
    end

    initial
    begin
        failures = 0;
        checked = 0;
        nrst = 1'b0;
        high_latch = 5'h1D;
        literal_ops();
        file_ops();
        clear_ops();
        skip_ops();
        call_ops();
        conclude();
    end
endmodule : tb_risc_core_instr_decode_subset
